// ===== src/i2cr_defines.vh
// Purpose: Shared constants for the serial register access port.
// Assumes: Included by bare name from every design file of the port.
// Notes: Bus addresses are the 7-bit forms of the two 8-bit write addresses.
`ifndef I2CR_DEFINES_VH
`define I2CR_DEFINES_VH
// ==========================================================================
// Slave addressing.
// Primary 7-bit address, the 8-bit write form being 0xD4.
`define I2CR_ADDR_PRI 7'h6A
// Secondary 7-bit address, the 8-bit write form being 0xD0.
`define I2CR_ADDR_SEC 7'h68
// Position of the address select bit in the address configuration byte.
`define I2CR_SEL_BIT 0
// ==========================================================================
// Timing.
// Core clock period in nanoseconds.
`define I2CR_CLK_NS 20
// Least internal hold of the data line after a falling serial clock, in ns.
`define I2CR_HOLD_NS 300
// Hold in core cycles, rounded up.
`define I2CR_HOLD_CYC ((`I2CR_HOLD_NS + `I2CR_CLK_NS - 1) / `I2CR_CLK_NS)
// Supported serial clock range in kHz, kept by the bus master.
`define I2CR_SCL_MIN_KHZ 10
`define I2CR_SCL_MAX_KHZ 400
// ==========================================================================
// Sizes and reset values.
// Number of bytes one block write can stage before commit.
`define I2CR_STAGE_DEPTH 16
// Width of the register position formed by the two address bytes.
`define I2CR_REG_AW 16
// Reset value of the register position.
`define I2CR_PTR_RST 16'h0000
`endif

// ===== src/i2cr_stage.v
// Purpose: Holds the data bytes of one block write and releases them at once.
// Assumes: Push and commit never arrive in the same cycle.
// Notes: Bytes above the committed count in the data output are stale.
`timescale 1ns/1ps
`include "i2cr_defines.vh"
module i2cr_stage #(
  parameter DEPTH = `I2CR_STAGE_DEPTH,
  parameter AW = `I2CR_REG_AW,
  parameter CW = $clog2(DEPTH + 1)
) (
  // Clock, reset and enable.
  input wire clk,
  input wire rst,
  input wire ce,
  // Byte input.
  input wire push,
  input wire [AW-1:0] push_addr,
  input wire [7:0] push_data,
  // Commit request.
  input wire commit,
  // Fill state.
  output wire full,
  output wire empty,
  output reg [AW-1:0] nxt_addr_reg,
  // Commit result.
  output reg commit_stb_reg,
  output reg [AW-1:0] commit_base_reg,
  output reg [CW-1:0] commit_cnt_reg,
  output reg [8*DEPTH-1:0] commit_data_reg
);
  // ========================================================================
  // Storage.
  localparam [31:0] DEPTH_FULL = DEPTH; // Depth at full integer width.
  localparam [CW-1:0] FULL_CNT = DEPTH_FULL[CW-1:0]; // Count at which the buffer is full.
  reg [8*DEPTH-1:0] buf_reg; // Staged bytes, first byte in the low lane.
  reg [CW-1:0] cnt_reg; // Number of bytes staged.
  reg [AW-1:0] base_reg; // Register position of the first staged byte.

  assign full = (cnt_reg == FULL_CNT);
  assign empty = (cnt_reg == {CW{1'b0}});

  // ========================================================================
  // Staging and commit process.
  // Nothing reaches the commit outputs until the commit request, so no register can change early.
  always @(posedge clk) begin
    if (rst) begin
      buf_reg <= {(8*DEPTH){1'b0}};
      cnt_reg <= {CW{1'b0}};
      base_reg <= {AW{1'b0}};
      nxt_addr_reg <= {AW{1'b0}};
      commit_stb_reg <= 1'b0;
      commit_base_reg <= {AW{1'b0}};
      commit_cnt_reg <= {CW{1'b0}};
      commit_data_reg <= {(8*DEPTH){1'b0}};
    end else if (ce) begin
      commit_stb_reg <= 1'b0;
      if (push && !full) begin
        // Byte i of the block goes to lane i, so it lands at base plus i.
        buf_reg[cnt_reg*8 +: 8] <= push_data;
        cnt_reg <= cnt_reg + 1'b1;
        nxt_addr_reg <= push_addr + 1'b1;
        if (empty) begin
          // The first byte fixes the block's base position.
          base_reg <= push_addr;
        end
      end else if (commit) begin
        // All staged bytes leave together in one strobe.
        commit_stb_reg <= 1'b1;
        commit_base_reg <= base_reg;
        commit_cnt_reg <= cnt_reg;
        commit_data_reg <= buf_reg;
        cnt_reg <= {CW{1'b0}};
      end
    end
  end
endmodule

// ===== src/i2cr_slave.v
// Purpose: Serial slave port giving block write and read access to configuration registers.
// Assumes: CORE_CLK far faster than the serial clock; register file and restore logic on CORE_CLK.
// Notes: The data line is open drain; the output enable pulls it low.
`timescale 1ns/1ps
`include "i2cr_defines.vh"
module i2cr_slave #(
  parameter DEPTH = `I2CR_STAGE_DEPTH,
  parameter AW = `I2CR_REG_AW,
  parameter CW = $clog2(DEPTH + 1)
) (
  // Clock, reset and enable.
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire CLK_EN,
  // Serial bus pins.
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  // Device state and configuration.
  input wire RESTORE_DONE,
  input wire [7:0] ADDR_CFG,
  // Register read port.
  output reg [AW-1:0] RD_ADDR,
  input wire [7:0] RD_DATA,
  // Register commit port.
  output wire COMMIT_STB,
  output wire [AW-1:0] COMMIT_BASE,
  output wire [CW-1:0] COMMIT_COUNT,
  output wire [8*DEPTH-1:0] COMMIT_DATA
);
  // ========================================================================
  // Constants.
  localparam [2:0] ST_IDLE = 3'h0; // Waiting for a START.
  localparam [2:0] ST_RX = 3'h1; // Receiving a byte from the master.
  localparam [2:0] ST_RXACK = 3'h2; // Driving our acknowledge.
  localparam [2:0] ST_TX = 3'h3; // Sending a read byte.
  localparam [2:0] ST_TXACK = 3'h4; // Master's acknowledge slot.
  localparam [2:0] ST_IGNORE = 3'h5; // Off the bus until the next START or STOP.
  localparam [1:0] K_ADDR = 2'h0; // Byte kinds within a transaction.
  localparam [1:0] K_REGH = 2'h1;
  localparam [1:0] K_REGL = 2'h2;
  localparam [1:0] K_DATA = 2'h3;
  localparam [31:0] HOLD_FULL = `I2CR_HOLD_CYC; // Data hold in core cycles, full integer width.
  localparam [4:0] HOLD_CYC = HOLD_FULL[4:0]; // Data hold cut to the width of its counter.

  // ========================================================================
  // Functions.
  // Kind of the byte that follows an acknowledged byte of the given kind.
  function [1:0] next_kind;
    input [1:0] kind;
    begin
      if (kind == K_DATA) begin
        next_kind = K_DATA;
      end else begin
        next_kind = kind + 2'h1;
      end
    end
  endfunction

  // ========================================================================
  // Signals.
  reg scl_meta_reg; // First synchroniser stages, read only by the second.
  reg sda_meta_reg;
  reg scl_s_reg; // Synchronised levels.
  reg sda_s_reg;
  reg scl_d_reg; // Delayed copies for edge detection.
  reg sda_d_reg;
  reg [2:0] state_reg; // Protocol state.
  reg [1:0] kind_reg; // Kind of the byte in progress.
  reg [3:0] bit_cnt_reg; // Bits shifted in the current byte.
  reg [7:0] shift_reg; // Byte shifter, MSB first.
  reg rw_reg; // Read flag of the address byte.
  reg nack_reg; // Master's answer in a read acknowledge slot.
  reg pend_reg; // Data line drive waiting for the hold to expire.
  reg [4:0] hold_cnt_reg; // Hold countdown.
  reg push_reg; // Pulse that stages one byte.
  reg [7:0] push_data_reg; // Byte being staged.
  reg [AW-1:0] push_addr_reg; // Register position of that byte.
  reg commit_reg; // Pulse that commits the staged block.
  wire stg_full; // Staging buffer state.
  wire stg_empty;
  wire [AW-1:0] stg_nxt;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire [6:0] my_addr;
  wire addr_hit;
  wire data_ok;

  // Edges and bus conditions seen on the synchronised pins only.
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  // Select bit clear gives the primary address.
  assign my_addr = ADDR_CFG[`I2CR_SEL_BIT] ? `I2CR_ADDR_SEC : `I2CR_ADDR_PRI;
  // Address is answered only when it matches and the restore is over.
  assign addr_hit = (shift_reg[7:1] == my_addr) && RESTORE_DONE;
  // A data byte is taken while room is left and it continues the staged run.
  assign data_ok = !stg_full && (stg_empty || (RD_ADDR == stg_nxt));

  // ========================================================================
  // Staging buffer.
  i2cr_stage #(
    .DEPTH(DEPTH),
    .AW(AW),
    .CW(CW)
  ) u_stage (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .push(push_reg),
    .push_addr(push_addr_reg),
    .push_data(push_data_reg),
    .commit(commit_reg),
    .full(stg_full),
    .empty(stg_empty),
    .nxt_addr_reg(stg_nxt),
    .commit_stb_reg(COMMIT_STB),
    .commit_base_reg(COMMIT_BASE),
    .commit_cnt_reg(COMMIT_COUNT),
    .commit_data_reg(COMMIT_DATA)
  );

  // ========================================================================
  // Protocol process.
  // Runs entirely on CORE_CLK; the serial clock is only sampled.
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      scl_meta_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      kind_reg <= K_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      pend_reg <= 1'b0;
      hold_cnt_reg <= 5'h00;
      push_reg <= 1'b0;
      push_data_reg <= 8'h00;
      push_addr_reg <= {AW{1'b0}};
      commit_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      RD_ADDR <= `I2CR_PTR_RST;
    end else if (CLK_EN) begin
      // Two-stage synchronisers, then one delay for edges.
      scl_meta_reg <= SCL_IN;
      sda_meta_reg <= SDA_IN;
      scl_s_reg <= scl_meta_reg;
      sda_s_reg <= sda_meta_reg;
      scl_d_reg <= scl_s_reg;
      sda_d_reg <= sda_s_reg;
      push_reg <= 1'b0;
      commit_reg <= 1'b0;
      // Outside START and STOP, a new drive level reaches the pin only after the hold has run out.
      if (hold_cnt_reg != 5'h00) begin
        hold_cnt_reg <= hold_cnt_reg - 5'h01;
        if (hold_cnt_reg == 5'h01) begin
          SDA_OE <= pend_reg;
        end
      end
      if (start_det) begin
        // START or repeated START: a new address byte follows.
        state_reg <= ST_RX;
        kind_reg <= K_ADDR;
        bit_cnt_reg <= 4'h0;
        hold_cnt_reg <= 5'h00;
        SDA_OE <= 1'b0;
      end else if (stop_det) begin
        // STOP ends any block; a staged write is committed now.
        state_reg <= ST_IDLE;
        hold_cnt_reg <= 5'h00;
        SDA_OE <= 1'b0;
        commit_reg <= !stg_empty;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (scl_rise) begin
              // Bits arrive MSB first.
              shift_reg <= {shift_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              hold_cnt_reg <= HOLD_CYC;
              pend_reg <= 1'b1;
              state_reg <= ST_RXACK;
              if (kind_reg == K_ADDR) begin
                rw_reg <= shift_reg[0];
                if (!addr_hit) begin
                  // Foreign or early address: no acknowledge, sit out the transaction.
                  pend_reg <= 1'b0;
                  state_reg <= ST_IGNORE;
                end
              end else if (kind_reg == K_REGH) begin
                // First address byte is the high half of the position.
                RD_ADDR[AW-1:8] <= shift_reg;
              end else if (kind_reg == K_REGL) begin
                RD_ADDR[7:0] <= shift_reg;
              end else if (data_ok) begin
                // Stage the byte and move to the next position.
                push_reg <= 1'b1;
                push_data_reg <= shift_reg;
                push_addr_reg <= RD_ADDR;
                RD_ADDR <= RD_ADDR + 1'b1;
              end else begin
                // No room or a gap in the run: refuse the byte.
                pend_reg <= 1'b0;
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_RXACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              hold_cnt_reg <= HOLD_CYC;
              kind_reg <= next_kind(kind_reg);
              if (kind_reg == K_ADDR && rw_reg) begin
                // Read: first byte comes from the current position.
                shift_reg <= RD_DATA;
                pend_reg <= ~RD_DATA[7];
                RD_ADDR <= RD_ADDR + 1'b1;
                state_reg <= ST_TX;
              end else begin
                pend_reg <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              hold_cnt_reg <= HOLD_CYC;
              if (bit_cnt_reg == 4'h8) begin
                // Release the line for the master's answer.
                pend_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                state_reg <= ST_TXACK;
              end else begin
                pend_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              nack_reg <= sda_s_reg;
            end else if (scl_fall) begin
              if (nack_reg) begin
                // Master ends the read after this whole byte.
                state_reg <= ST_IGNORE;
              end else begin
                shift_reg <= RD_DATA;
                pend_reg <= ~RD_DATA[7];
                hold_cnt_reg <= HOLD_CYC;
                RD_ADDR <= RD_ADDR + 1'b1;
                state_reg <= ST_TX;
              end
            end
          end
          default: begin
            // Idle or ignoring: the line stays released.
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end
endmodule

// ===== verif/i2cr_checker.sv
// Purpose: Assertions on the pins and commit outputs of the serial register port.
// Assumes: CLK_EN held high, so cycles counted here match the port's view.
// Notes: Pin events are counted at the raw pins, ahead of the port's synchronisers.
`timescale 1ns/1ps
`include "i2cr_defines.vh"
module i2cr_checker #(
  parameter DEPTH = 16,
  parameter AW = 16,
  parameter CW = 5
) (
  // Clock and reset.
  input wire CORE_CLK,
  input wire SYS_RST,
  // Bus pins.
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  // Device state.
  input wire RESTORE_DONE,
  // Commit port.
  input wire COMMIT_STB,
  input wire [AW-1:0] COMMIT_BASE,
  input wire [CW-1:0] COMMIT_COUNT
);
  // ==========================================================
  // Pin history.
  localparam int HOLD = `I2CR_HOLD_CYC; // Hold in core cycles.
  logic scl_reg; // Last sampled clock pin.
  logic sda_reg; // Last sampled data pin.
  logic wait_reg; // Set until a START follows a restore that was unfinished.
  logic [7:0] low_reg; // Cycles the clock pin has been low.
  logic [7:0] evt_reg; // Cycles since a START or STOP.
  logic [7:0] stop_reg; // Cycles since a STOP.
  wire evt = SCL_IN && scl_reg && (SDA_IN != sda_reg); // Data edge while clock high.
  // Counters saturate so that a long idle bus cannot wrap them.
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      wait_reg <= 1'b1;
      low_reg <= 8'hFF;
      evt_reg <= 8'hFF;
      stop_reg <= 8'hFF;
    end else begin
      scl_reg <= SCL_IN;
      sda_reg <= SDA_IN;
      wait_reg <= !RESTORE_DONE ? 1'b1 : ((evt && !SDA_IN) ? 1'b0 : wait_reg);
      low_reg <= SCL_IN ? 8'h00 : low_reg + {7'h00, low_reg != 8'hFF};
      evt_reg <= evt ? 8'h00 : evt_reg + {7'h00, evt_reg != 8'hFF};
      stop_reg <= (evt && SDA_IN) ? 8'h00 : stop_reg + {7'h00, stop_reg != 8'hFF};
    end
  end
  // ==========================================================
  // Properties.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_one_pulse;
    COMMIT_STB ##1 !COMMIT_STB;
  endsequence
  AST_HOLD_RISE: assert property ($rose(SDA_OE) |-> !SCL_IN && low_reg >= HOLD + 2)
    else $error("data line pulled too soon after a clock fall");
  AST_HOLD_FALL: assert property ($fell(SDA_OE) |-> low_reg >= HOLD + 2 || evt_reg <= 6)
    else $error("data line released too soon after a clock fall");
  AST_OPEN_DRAIN: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  AST_NOT_READY: assert property (wait_reg |-> !SDA_OE)
    else $error("bus answered before restore finished");
  AST_COMMIT_AT_STOP: assert property (COMMIT_STB |-> stop_reg inside {[3:7]})
    else $error("commit not tied to a stop");
  AST_STB_PULSE: assert property ($rose(COMMIT_STB) |-> s_one_pulse)
    else $error("commit strobe longer than one cycle");
  AST_COMMIT_HELD: assert property (!COMMIT_STB |-> $stable(COMMIT_BASE) && $stable(COMMIT_COUNT))
    else $error("commit outputs changed without strobe");
  AST_COUNT_RANGE: assert property (COMMIT_STB |-> COMMIT_COUNT >= 1 && COMMIT_COUNT <= DEPTH)
    else $error("commit count out of range");
endmodule
bind i2cr_slave i2cr_checker #(.DEPTH(DEPTH), .AW(AW), .CW(CW)) u_checker (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .RESTORE_DONE(RESTORE_DONE), .COMMIT_STB(COMMIT_STB),
  .COMMIT_BASE(COMMIT_BASE), .COMMIT_COUNT(COMMIT_COUNT));

// ===== verif/i2cr_master_model.sv
// Purpose: Behavioural bus master that drives the serial clock and data line.
// Assumes: The data line has a pull-up; the master only pulls it low.
// Notes: Timing runs on its own delays, unrelated in phase to the core clock.
`timescale 1ns/1ps
module i2cr_master_model #(
  parameter int QTR_NS = 640
) (
  // Lines driven by the master.
  output logic scl,
  output logic sda_pull,
  // Wired level of the data line.
  input wire logic sda
);
  // The bus idles released, clock high.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One bit: data set a quarter after the fall, sampled mid-high; period near 390 kHz.
  task automatic clk_bit(input logic b, output logic got);
    sda_pull = !b;
    #QTR_NS scl = 1'b1;
    #QTR_NS got = sda;
    #QTR_NS scl = 1'b0;
    #QTR_NS;
  endtask
  // START or repeated START: data falls while the clock is high.
  task automatic send_start();
    sda_pull = 1'b0;
    #QTR_NS scl = 1'b1;
    #QTR_NS sda_pull = 1'b1;
    #QTR_NS scl = 1'b0;
    #QTR_NS;
  endtask
  // STOP: data rises while the clock is high.
  task automatic send_stop();
    sda_pull = 1'b1;
    #QTR_NS scl = 1'b1;
    #QTR_NS sda_pull = 1'b0;
    #QTR_NS;
    // Extra idle so the bus free time before a following START is kept.
    #QTR_NS;
  endtask
  // Byte out, MSB first, then the acknowledge slot; nack is high when unanswered.
  task automatic wr_byte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], nack);
    clk_bit(1'b1, nack);
  endtask
  // Byte in, MSB first; the last byte of a block is refused to end it.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, g);
  endtask
endmodule

// ===== verif/i2c_block_register_access_test.sv
// Purpose: Self-checking bench for block writes and reads through the serial port.
// Assumes: A register image in the bench answers the read port and takes commits.
// Notes: Scenarios run in order and share the commit count.
`timescale 1ns/1ps
// Compares a seen value with its expected value and counts both outcomes.
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module i2c_block_register_access_test;
  // ==========================================================
  // Signals.
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic restore_done = 1'b0;
  logic [7:0] addr_cfg = 8'h00;
  logic [7:0] regs [256]; // Register image behind the read port.
  wire scl, m_pull, sda_oe, sda_out, commit_stb;
  wire sda_bus = !(sda_oe || m_pull); // Pull-up: a released line reads high.
  wire [15:0] rd_addr, commit_base;
  wire [4:0] commit_count;
  wire [127:0] commit_data;
  wire [7:0] rd_data = regs[rd_addr[7:0]];
  int error_cnt = 0;
  int num_checks = 0;
  int n_commit = 0;
  always #10 core_clk = ~core_clk;
  i2cr_slave dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .SCL_IN(scl),
    .SDA_IN(sda_bus), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .RESTORE_DONE(restore_done),
    .ADDR_CFG(addr_cfg), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .COMMIT_STB(commit_stb),
    .COMMIT_BASE(commit_base), .COMMIT_COUNT(commit_count), .COMMIT_DATA(commit_data));
  i2cr_master_model m (.scl(scl), .sda_pull(m_pull), .sda(sda_bus));
  // The image starts with a pattern and takes every committed block.
  initial for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5A;
  always @(posedge core_clk) begin
    if (commit_stb === 1'b1) begin
      n_commit++;
      for (int i = 0; i < commit_count; i++) regs[8'(commit_base + i)] = commit_data[8*i +: 8];
    end
  end
  // ==========================================================
  // Shared tasks.
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] d, input logic exp_nack, input string nm);
    logic nack;
    m.wr_byte(d, nack);
    `CHK(nm, exp_nack, nack)
  endtask
  task automatic set_in(input logic rd, input logic [7:0] cfg);
    @(posedge core_clk);
    #2;
    restore_done = rd;
    addr_cfg = cfg;
  endtask
  // Bounded wait for the commit count to reach n.
  task automatic wait_commit(input int n);
    for (int i = 0; i < 200 && n_commit != n; i++) begin
      @(posedge core_clk);
      #2;
    end
    `CHK("commits", n, n_commit)
    if (n_commit != n) give_verdict();
  endtask
  // ==========================================================
  // Scenarios.
  task automatic sc_not_ready();
    m.send_start();
    send(8'hD4, 1'b1, "address while restoring");
    send(8'h00, 1'b1, "byte after refusal");
    m.send_stop();
    `CHK("commits while restoring", 0, n_commit)
    set_in(1'b1, 8'h00);
  endtask
  task automatic sc_write();
    logic [7:0] wd [3] = '{8'hA5, 8'h3C, 8'h0F};
    m.send_start();
    send(8'hD4, 1'b0, "primary address");
    send(8'h00, 1'b0, "position high");
    send(8'h12, 1'b0, "position low");
    `CHK("start position", 16'h0012, rd_addr)
    foreach (wd[i]) send(wd[i], 1'b0, "block data");
    `CHK("pointer after block", 16'h0015, rd_addr)
    `CHK("commits before stop", 0, n_commit)
    m.send_stop();
    wait_commit(1);
    `CHK("commit base", 16'h0012, commit_base)
    `CHK("commit count", 5'h03, commit_count)
    `CHK("commit data", 24'h0F3CA5, commit_data[23:0])
  endtask
  task automatic sc_read();
    logic [7:0] rexp [4] = '{8'h4B, 8'hA5, 8'h3C, 8'h0F};
    logic [7:0] got;
    m.send_start();
    send(8'hD4, 1'b0, "primary address");
    send(8'h00, 1'b0, "position high");
    send(8'h11, 1'b0, "position low");
    m.send_start();
    send(8'hD5, 1'b0, "read address");
    foreach (rexp[i]) begin
      m.rd_byte(i == 3, got);
      `CHK("read data", rexp[i], got)
    end
    m.send_stop();
    `CHK("address-only write", 1, n_commit)
  endtask
  task automatic sc_addr_sel();
    set_in(1'b1, 8'h01);
    m.send_start();
    send(8'hD4, 1'b1, "primary when secondary set");
    send(8'h00, 1'b1, "ignored byte");
    m.send_stop();
    `CHK("ignored transaction", 1, n_commit)
    m.send_start();
    send(8'hD0, 1'b0, "secondary address");
    send(8'h00, 1'b0, "position high");
    send(8'h20, 1'b0, "position low");
    send(8'hC3, 1'b0, "single byte");
    m.send_stop();
    wait_commit(2);
    `CHK("single base", 16'h0020, commit_base)
    `CHK("single count", 5'h01, commit_count)
    `CHK("single data", 8'hC3, commit_data[7:0])
  endtask
  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    repeat (12) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #2;
    sc_not_ready();
    sc_write();
    sc_read();
    sc_addr_sel();
    give_verdict();
  end
  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end
endmodule
